// [src/bsl_seq.sv]
// Contract
// - Post purge steps 1 s, 10 s, 1 min.
// - Fan runs post purge after demand drops.
// - Commit setting after five second reset hold.
// - Setting changes only in standby with password.
// - Initiate locks out on missing or bad card.
// - Jumper change after 200 hours locks out.
// - Initiate longer than four minutes locks out.
// - Airflow not proven in time locks out; with airflow_failure_action_jumper high the purge restarts.
// - Standby flame for 240 seconds locks out.
// - Standby valve energised or interlock open locks out.
// - Prepurge flame, airflow, valve, interlock faults lock out.
// - Internal or card faults lock out standby to run.
// - Pilot trial flame, pilot, main checks.
// - Main trial flame, ignition, valve checks.
// - Run valve, ignition, airflow, flame checks.
// - Special variant: early run flame loss locks out.
// - Initiate or standby shutdown locks out with alarm.
// - Purge shutdown drops blower at once.
// - Trial or run shutdown: fuel off, post purge.
// - Unprogrammed post purge defaults to 15 seconds.
// - Lockout leaves only on manual reset.
// - Lockout survives power interruption.
// - Pilot trial ten or four seconds.
// - Flame loss recycles or locks out per jumper.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module bsl_seq
   import bsl_pkg::*;
#(
   parameter int       TICK_CYCLES     = TICK_CYC,
   parameter bit       SPECIAL_RECYCLE = 1'b0,
   parameter int       MAIN_TRIAL_PERIOD_S          = T_MAIN_TRIAL_PERIOD_S
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Field inputs
   input  var  bsl_fb_t     fb_i,
   input  var  bsl_jmp_t    jmp_i,
   input  wire logic        heat_demand_i,
   input  wire logic        line_ok_i,
   input  wire logic        card_present_i,
   input  wire logic        card_ok_i,
   input  wire logic [10:0] card_purge_s_i,
   input  wire logic        int_fault_i,
   input  wire logic        reset_btn_i,
   input  wire logic        remote_reset_i,
   input  wire logic        nv_lockout_i,
   // Loads and status
   output bsl_load_t        loads_o,
   output logic             nv_lockout_o
);

   if (TICK_CYCLES < 1 || TICK_CYCLES >= 2**26 || MAIN_TRIAL_PERIOD_S < 1 || MAIN_TRIAL_PERIOD_S > 4000) begin : g_chk
      $error("bsl_seq: parameter out of range");
   end

   localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);

   typedef struct packed {
      bsl_state_t  state;
      logic [25:0] tick;
      logic [11:0] sec;
      logic [3:0]  init_ok;
      logic [19:0] op_secs;
      logic [2:0]  hold;
      logic [11:0] pp_left;
      logic [7:0]  pp_idx;
      logic        pp_valid;
      logic [7:0]  pend_idx;
      logic        pend;
      logic        unlocked;
      logic        booted;
      logic        air_ok;
      bsl_jmp_t    jmp_ref;
      logic [7:0]  fault;
      logic        nonres;
      bsl_load_t   ld;
      logic        ack;
      logic [31:0] dat;
   } bsl_regs_t;

   bsl_regs_t s_r;
   bsl_regs_t s_nxt;

   function automatic logic [11:0] pp_secs(input logic [7:0] idx);
      if (idx <= PP_IDX_SEC_END) begin
         pp_secs = {4'h0, idx};
      end else if (idx <= PP_IDX_TEN_END) begin
         pp_secs = 12'(60 + (12'(idx) - 12'(PP_IDX_SEC_END)) * 10);
      end else begin
         pp_secs = 12'(600 + (12'(idx) - 12'(PP_IDX_TEN_END)) * 60);
      end
   endfunction : pp_secs

   logic        sec_tick;
   logic [11:0] pp_time;
   logic [11:0] pilot_trial_period_len;
   logic [11:0] air_lim;
   logic        lo;
   logic [7:0]  code;
   logic        bus_wr;

   assign sec_tick = (s_r.tick == TICK_LAST);
   assign pp_time  = s_r.pp_valid ? pp_secs(s_r.pp_idx) : 12'(T_PP_DEF_S);
   assign pilot_trial_period_len = jmp_i.pilot_trial_length_jumper ? 12'(T_PILOT_TRIAL_PERIOD_LONG_S)
                                                     : 12'(T_PILOT_TRIAL_PERIOD_SHORT_S);
   assign air_lim  = ({1'b0, card_purge_s_i} < 12'(T_AIR_S)) ? {1'b0, card_purge_s_i}
                                                             : 12'(T_AIR_S);
   assign bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack & wb_sel_i[0];

   always_comb begin
      s_nxt = s_r;
      lo    = 1'b0;
      code  = FLT_NONE;
      s_nxt.ack    = wb_cyc_i & wb_stb_i & ~s_r.ack;
      s_nxt.booted = 1'b1;
      if (!s_r.booted) s_nxt.jmp_ref = jmp_i;
      s_nxt.tick   = sec_tick ? 26'h0 : s_r.tick + 26'h1;
      // Every period timer counts this one shared second tick.
      if (sec_tick) begin
         if (s_r.sec != 12'hFFF) s_nxt.sec = s_r.sec + 12'h1;
         if (s_r.op_secs != 20'hFFFFF) s_nxt.op_secs = s_r.op_secs + 20'h1;
         if (s_r.pp_left != 12'h0) s_nxt.pp_left = s_r.pp_left - 12'h1;
      end
      if (!reset_btn_i) begin
         s_nxt.hold = 3'h0;
      end else if (sec_tick && s_r.hold < 3'(T_COMMIT_S)) begin
         s_nxt.hold = s_r.hold + 3'h1;
      end

      if (s_r.pend && s_r.hold == 3'(T_COMMIT_S)) begin
         s_nxt.pp_idx   = s_r.pend_idx;
         s_nxt.pp_valid = 1'b1;
         s_nxt.pend     = 1'b0;
      end
      // Setup access only from standby; a write beside a commit stays pending.
      if (bus_wr && wb_adr_i == REG_PASS) begin
         s_nxt.unlocked = (s_r.state == ST_STANDBY) && (wb_dat_i[7:0] == SETUP_PASS);
      end else if (bus_wr && wb_adr_i == REG_PPSET && s_r.unlocked) begin
         s_nxt.pend_idx = (wb_dat_i[7:0] > PP_IDX_MAX) ? PP_IDX_MAX : wb_dat_i[7:0];
         s_nxt.pend     = 1'b1;
      end

      case (s_r.state)
         ST_INIT: begin
            s_nxt.ld = '0;
            if (sec_tick) s_nxt.init_ok = line_ok_i ? s_r.init_ok + 4'h1 : 4'h0;
            if (!s_r.booted && nv_lockout_i) begin
               lo = 1'b1;
               code = FLT_NVM;
            end else if (!card_present_i || !card_ok_i) begin
               lo = 1'b1;
               code = FLT_CARD;
            end else if (s_r.sec >= 12'(T_INIT_MAX_S)) begin
               lo = 1'b1;
               code = FLT_INIT;
            end else if (s_r.init_ok >= 4'(T_INIT_S)) begin
               s_nxt.state = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            s_nxt.ld = '0;
            if (fb_i.flame && s_r.sec >= 12'(T_FLAME_SBY_S)) begin
               lo = 1'b1;
               code = FLT_FLAME;
            end else if (fb_i.pilot || fb_i.main || fb_i.dmain || !fb_i.preign) begin
               lo = 1'b1;
               code = FLT_LOAD;
            end else if (heat_demand_i) begin
               s_nxt.state = ST_PREPURGE;
               s_nxt.ld.blower = 1'b1;
               s_nxt.air_ok = 1'b0;
            end
            if (!fb_i.flame) s_nxt.sec = 12'h0;
         end
         ST_PREPURGE: begin
            if (fb_i.airflow) s_nxt.air_ok = 1'b1;
            if (fb_i.flame && s_r.sec >= 12'(T_FLAME_PRE_S)) begin
               lo = 1'b1;
               code = FLT_FLAME;
            end else if (fb_i.pilot || fb_i.ign || fb_i.main || fb_i.dmain) begin
               lo = 1'b1;
               code = FLT_LOAD;
            end else if (!fb_i.preign) begin
               lo = 1'b1;
               code = FLT_ILK;
            end else if ((s_r.air_ok && !fb_i.airflow)
                         || (!s_r.air_ok && !fb_i.airflow && s_r.sec >= air_lim)) begin
               if (!jmp_i.airflow_failure_action_jumper) begin
                  lo = 1'b1;
                  code = FLT_AIR;
               end else begin
                  s_nxt.sec = 12'h0;
                  s_nxt.air_ok = 1'b0;
               end
            end else if (!heat_demand_i) begin
               s_nxt.state = ST_STANDBY;
               s_nxt.ld = '0;
            end else if (s_r.air_ok && s_r.sec >= {1'b0, card_purge_s_i}) begin
               s_nxt.state = ST_PILOT;
               s_nxt.ld.pilot = 1'b1;
               s_nxt.ld.ign = 1'b1;
            end
         end
         ST_PILOT: begin
            if ((fb_i.main || fb_i.dmain)
                || (s_r.sec != 12'h0 && !fb_i.pilot)) begin
               lo = 1'b1;
               code = FLT_LOAD;
            end else if (!jmp_i.airflow_failure_action_jumper && !fb_i.airflow) begin
               lo = 1'b1;
               code = FLT_AIR;
            end else if (s_r.sec >= pilot_trial_period_len) begin
               if (!fb_i.flame) begin
                  lo = 1'b1;
                  code = FLT_NOFLM;
               end else begin
                  s_nxt.state = ST_MAIN;
                  s_nxt.ld.ign = 1'b0;
                  s_nxt.ld.main = 1'b1;
               end
            end
         end
         ST_MAIN: begin
            if (!fb_i.flame) begin
               lo = 1'b1;
               code = FLT_NOFLM;
            end else if (fb_i.ign || fb_i.dmain
                         || (s_r.sec != 12'h0 && (!fb_i.pilot || !fb_i.main))) begin
               lo = 1'b1;
               code = FLT_LOAD;
            end else if (!jmp_i.airflow_failure_action_jumper && !fb_i.airflow) begin
               lo = 1'b1;
               code = FLT_AIR;
            end else if (s_r.sec >= 12'(MAIN_TRIAL_PERIOD_S)) begin
               s_nxt.state = ST_RUN;
               s_nxt.ld.pilot = 1'b0;
               s_nxt.ld.dmain = 1'b1;
            end
         end
         ST_RUN: begin
            if (fb_i.ign || (s_r.sec != 12'h0 && (fb_i.pilot || !fb_i.main || !fb_i.dmain))) begin
               lo = 1'b1;
               code = FLT_LOAD;
            end else if (!jmp_i.airflow_failure_action_jumper && !fb_i.airflow) begin
               lo = 1'b1;
               code = FLT_AIR;
            end else if (!fb_i.flame && !jmp_i.flame_failure_action_jumper
                         && !(SPECIAL_RECYCLE && s_r.sec >= 12'(T_SPECIAL_S))) begin
               lo = 1'b1;
               code = FLT_NOFLM;
            end else if (!fb_i.flame || !heat_demand_i) begin
               s_nxt.state = ST_POSTPURGE;
               s_nxt.ld = '0;
               s_nxt.ld.blower = 1'b1;
               s_nxt.pp_left = pp_time;
            end
         end
         ST_POSTPURGE: begin
            s_nxt.ld.blower = (s_nxt.pp_left != 12'h0);
            if (s_r.pp_left == 12'h0) s_nxt.state = ST_STANDBY;
         end
         default: begin
            s_nxt.ld = '0;
            s_nxt.ld.alarm = 1'b1;
            s_nxt.ld.blower = (s_nxt.pp_left != 12'h0);
            if ((reset_btn_i || remote_reset_i) && !s_r.nonres && s_r.pp_left == 12'h0) begin
               s_nxt.state = ST_INIT;
               s_nxt.ld.alarm = 1'b0;
               s_nxt.fault = FLT_NONE;
               s_nxt.init_ok = 4'h0;
            end
         end
      endcase

      if (s_r.state inside {ST_STANDBY, ST_PREPURGE, ST_PILOT, ST_MAIN, ST_RUN}) begin
         if (int_fault_i) begin
            lo = 1'b1;
            code = FLT_INT;
         end else if (!card_present_i || !card_ok_i) begin
            lo = 1'b1;
            code = FLT_CARD;
         end
      end
      if (s_r.state != ST_LOCKOUT && jmp_i != s_r.jmp_ref
          && s_r.op_secs > 20'(T_JMP_S)) begin
         lo = 1'b1;
         code = FLT_JMP;
         s_nxt.nonres = 1'b1;
      end

      // Trial and run shutdowns keep the fan for post purge; others stop it at once.
      if (lo) begin
         s_nxt.state = ST_LOCKOUT;
         s_nxt.fault = code;
         s_nxt.ld = '0;
         s_nxt.ld.alarm = 1'b1;
         if (s_r.state inside {ST_PILOT, ST_MAIN, ST_RUN}) begin
            s_nxt.ld.blower = 1'b1;
            s_nxt.pp_left = pp_time;
         end else begin
            s_nxt.pp_left = 12'h0;
         end
      end
      if (s_nxt.state != ST_STANDBY) s_nxt.unlocked = 1'b0;
      if (s_nxt.state != s_r.state) s_nxt.sec = 12'h0;

      s_nxt.dat = 32'h0;
      if (wb_adr_i == REG_STATUS) begin
         s_nxt.dat = {16'h0, s_r.fault, 1'b0, s_r.nonres, s_r.pend, s_r.unlocked, s_r.state};
      end else if (wb_adr_i == REG_PPSET) begin
         s_nxt.dat = {23'h0, s_r.pp_valid, s_r.pp_idx};
      end else if (wb_adr_i == REG_PPTIME) begin
         s_nxt.dat = {20'h0, pp_time};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_ack_o     = s_r.ack;
   assign wb_dat_o     = s_r.dat;
   assign loads_o      = s_r.ld;
   assign nv_lockout_o = s_r.ld.alarm;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !s_r.ack;
   endsequence
   sequence s_lock_entry_trial;
      (s_r.state inside {ST_PILOT, ST_MAIN, ST_RUN}) ##1 (s_r.state == ST_LOCKOUT);
   endsequence

   property p_ack;
      s_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not single cycle");
   property p_pp_default;
      !s_r.pp_valid |-> pp_time == 12'd15;
   endproperty
   a_pp_default: assert property (p_pp_default) else $error("default post purge wrong");

   property p_sby_flame;
      (s_r.state == ST_STANDBY && fb_i.flame && s_r.sec >= 12'd240) |=> s_r.state == ST_LOCKOUT;
   endproperty
   a_sby_flame: assert property (p_sby_flame) else $error("standby flame no lockout");
   property p_lock_loads;
      s_r.state == ST_LOCKOUT |-> loads_o.alarm && loads_o[4:1] == 4'h0;
   endproperty
   a_lock_loads: assert property (p_lock_loads) else $error("lockout loads wrong");

   property p_purge_blower;
      (s_r.state == ST_PREPURGE) ##1 (s_r.state == ST_LOCKOUT) |-> !loads_o.blower;
   endproperty
   a_purge_blower: assert property (p_purge_blower) else $error("blower on after purge trip");
   property p_trial_pp;
      s_lock_entry_trial |-> loads_o.blower && s_r.pp_left == $past(pp_time);
   endproperty
   a_trial_pp: assert property (p_trial_pp) else $error("no post purge after trip");

   property p_reset_exit;
      (s_r.state == ST_LOCKOUT) ##1 (s_r.state != ST_LOCKOUT)
         |-> $past(reset_btn_i || remote_reset_i) && s_r.state == ST_INIT;
   endproperty
   a_reset_exit: assert property (p_reset_exit) else $error("lockout left without reset");

   property p_commit;
      (s_r.pend && s_r.hold == 3'd5) |=> s_r.pp_valid && s_r.pp_idx == $past(s_r.pend_idx);
   endproperty
   a_commit: assert property (p_commit) else $error("post purge not committed");

   property p_pilot_len;
      s_r.state == ST_PILOT |-> s_r.sec <= (jmp_i.pilot_trial_length_jumper ? 12'd10 : 12'd4);
   endproperty
   a_pilot_len: assert property (p_pilot_len) else $error("pilot trial too long");

endmodule : bsl_seq
`default_nettype wire

// [inc/bsl_pkg.sv]
package bsl_pkg;

   // Timebase and period lengths, each in its own unit.
   localparam int CLK_HZ          = 40_000_000;
   localparam int T_BASE_S        = 1;
   localparam int TICK_CYC        = CLK_HZ * T_BASE_S;
   localparam int T_INIT_S        = 10;
   localparam int T_INIT_MAX_MIN  = 4;
   localparam int T_INIT_MAX_S    = T_INIT_MAX_MIN * 60;
   localparam int T_AIR_S         = 10;
   localparam int T_FLAME_SBY_S   = 240;
   localparam int T_FLAME_PRE_S   = 30;
   localparam int T_PILOT_TRIAL_PERIOD_LONG_S   = 10;
   localparam int T_PILOT_TRIAL_PERIOD_SHORT_S  = 4;
   localparam int T_MAIN_TRIAL_PERIOD_S        = 10;
   localparam int T_SPECIAL_S     = 15;
   localparam int T_PP_DEF_S      = 15;
   localparam int T_COMMIT_S      = 5;
   localparam int T_JMP_HOURS     = 200;
   localparam int T_JMP_S         = T_JMP_HOURS * 3600;

   // Post-purge step table limits.
   localparam logic [7:0] PP_IDX_SEC_END = 8'h3C;
   localparam logic [7:0] PP_IDX_TEN_END = 8'h72;
   localparam logic [7:0] PP_IDX_MAX     = 8'hA4;

   // Register byte offsets.
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_PASS   = 8'h04;
   localparam logic [7:0] REG_PPSET  = 8'h08;
   localparam logic [7:0] REG_PPTIME = 8'h0C;
   localparam logic [7:0] SETUP_PASS = 8'h78;

   // Fault codes.
   localparam logic [7:0] FLT_NONE  = 8'h00;
   localparam logic [7:0] FLT_CARD  = 8'h01;
   localparam logic [7:0] FLT_INIT  = 8'h02;
   localparam logic [7:0] FLT_FLAME = 8'h03;
   localparam logic [7:0] FLT_LOAD  = 8'h04;
   localparam logic [7:0] FLT_ILK   = 8'h05;
   localparam logic [7:0] FLT_AIR   = 8'h06;
   localparam logic [7:0] FLT_NOFLM = 8'h07;
   localparam logic [7:0] FLT_INT   = 8'h08;
   localparam logic [7:0] FLT_NVM   = 8'h09;
   localparam logic [7:0] FLT_JMP   = 8'h6E;

   typedef enum logic [3:0] {
      ST_INIT, ST_STANDBY, ST_PREPURGE, ST_PILOT, ST_MAIN, ST_RUN, ST_POSTPURGE, ST_LOCKOUT
   } bsl_state_t;

   // Field feedback, all active high.
   typedef struct packed {
      logic flame;
      logic airflow;
      logic preign;
      logic pilot;
      logic ign;
      logic main;
      logic dmain;
   } bsl_fb_t;

   // Jumpers, high while intact.
   typedef struct packed {
      logic airflow_failure_action_jumper;
      logic flame_failure_action_jumper;
      logic pilot_trial_length_jumper;
   } bsl_jmp_t;

   typedef struct packed {
      logic blower;
      logic pilot;
      logic ign;
      logic main;
      logic dmain;
      logic alarm;
   } bsl_load_t;

endpackage : bsl_pkg

// [dv/bsl_field_model.sv]
`timescale 1ns/10ps
`default_nettype none
module bsl_field_model
   import bsl_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Loads and flame request
   input  var  bsl_load_t loads_i,
   input  wire logic      flame_i,
   input  wire logic      nv_lockout_i,
   // Feedback to the sequencer
   output bsl_fb_t        fb_o,
   output logic           nv_lockout_o
);
   logic nv_r = 1'b0;
   // Relays echo their coils at once, so the sequencer never sees a mismatch.
   always_comb begin
      fb_o.flame   = flame_i;
      fb_o.airflow = loads_i.blower;
      fb_o.preign  = 1'b1;
      fb_o.pilot   = loads_i.pilot;
      fb_o.ign     = loads_i.ign;
      fb_o.main    = loads_i.main;
      fb_o.dmain   = loads_i.dmain;
   end
   // The store freezes while reset is held, as a power loss would.
   always_ff @(posedge clk_i) begin
      if (!rst_i) begin
         nv_r <= nv_lockout_i;
      end
   end
   assign nv_lockout_o = nv_r;
endmodule : bsl_field_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb
   import bsl_pkg::*;
;
   localparam int TK = 4;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   bsl_fb_t     fb;
   bsl_jmp_t    jmp = 3'h7;
   bsl_load_t   loads;
   logic        dem = 1'b0;
   logic        card = 1'b1;
   logic        cok = 1'b1;
   logic        lok = 1'b1;
   logic        flt = 1'b0;
   logic        btn = 1'b0;
   logic        rmt = 1'b0;
   logic        flame = 1'b0;
   logic        nv_o;
   logic        nv_i;
   logic [31:0] d;
   int          n;
   int          n_mismatch = 0;
   int          check_count = 0;

   always #12.5 clk_i = ~clk_i;

   bsl_seq #(.TICK_CYCLES(TK)) bsl_seq_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .fb_i(fb), .jmp_i(jmp), .heat_demand_i(dem), .line_ok_i(lok),
      .card_present_i(card), .card_ok_i(cok), .card_purge_s_i(11'h003),
      .int_fault_i(flt), .reset_btn_i(btn), .remote_reset_i(rmt),
      .nv_lockout_i(nv_i), .loads_o(loads), .nv_lockout_o(nv_o));

   bsl_field_model bsl_field_model_i (
      .clk_i(clk_i), .rst_i(rst_i), .loads_i(loads), .flame_i(flame),
      .nv_lockout_i(nv_o), .fb_o(fb), .nv_lockout_o(nv_i));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Classic single cycle; the request stands until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= v;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1);
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      chk("ack cycles", 32'h2, k);
   endtask : wb

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, d);
   endtask : rdc

   task automatic wst(input logic [3:0] s);
      n = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (d[3:0] !== s && n < 400);
      chk("state", {28'h0, s}, {28'h0, d[3:0]});
   endtask : wst

   task automatic ld(input logic [5:0] e);
      chk("loads", {26'h0, e}, {26'h0, loads});
   endtask : ld

   task automatic hold(input int t);
      btn <= 1'b1;
      repeat (t * TK) @(posedge clk_i);
      btn <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : hold

   task automatic t_reset();
      ld(6'h00);
      rdc("status", REG_STATUS, 32'h0);
      rdc("pptime", REG_PPTIME, 32'h0F);
      rdc("unmapped", 8'h10, 32'h0);
      wst(4'h1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_setting();
      logic [7:0]  ix [5] = '{8'h3C, 8'h3D, 8'h73, 8'hC8, 8'h02};
      logic [31:0] sec [5] = '{32'h3C, 32'h46, 32'h294, 32'hE10, 32'h2};
      wb(1'b1, REG_PPSET, 32'h5);
      hold(6);
      rdc("ppset", REG_PPSET, 32'h0);
      wb(1'b1, REG_PASS, {24'h0, SETUP_PASS});
      wb(1'b1, REG_PPSET, 32'h5);
      hold(2);
      rdc("ppset", REG_PPSET, 32'h0);
      foreach (ix[i]) begin
         wb(1'b1, REG_PPSET, {24'h0, ix[i]});
         hold(6);
         rdc("ppset", REG_PPSET, {23'h1, (ix[i] > PP_IDX_MAX) ? PP_IDX_MAX : ix[i]});
         rdc("pptime", REG_PPTIME, sec[i]);
      end
      $display("test setting done");
   endtask : t_setting

   task automatic t_cycle();
      dem <= 1'b1;
      wst(4'h2);
      ld(6'h20);
      wst(4'h3);
      ld(6'h38);
      flame <= 1'b1;
      wst(4'h4);
      chk("pilot len", 32'h1, 32'((n >= 10) && (n <= 15)));
      ld(6'h34);
      wst(4'h5);
      ld(6'h26);
      dem <= 1'b0;
      wst(4'h6);
      ld(6'h20);
      flame <= 1'b0;
      wst(4'h1);
      chk("pp len", 32'h1, 32'((n >= 1) && (n <= 6)));
      ld(6'h00);
      $display("test cycle done");
   endtask : t_cycle

   task automatic t_trip();
      jmp <= 3'h4;
      dem <= 1'b1;
      wst(4'h3);
      flame <= 1'b1;
      wst(4'h4);
      chk("short pilot", 32'h1, 32'((n >= 3) && (n <= 7)));
      wst(4'h5);
      flame <= 1'b0;
      wst(4'h7);
      ld(6'h21);
      chk("nv", 32'h1, {31'h0, nv_o});
      dem <= 1'b0;
      repeat (20) @(posedge clk_i);
      ld(6'h01);
      jmp <= 3'h7;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wst(4'h7);
      repeat (20) @(posedge clk_i);
      btn <= 1'b1;
      wst(4'h0);
      btn <= 1'b0;
      wst(4'h1);
      $display("test trip done");
   endtask : t_trip

   task automatic t_hold();
      dem <= 1'b1;
      wst(4'h3);
      flame <= 1'b1;
      wst(4'h5);
      flame <= 1'b0;
      wst(4'h6);
      ld(6'h20);
      dem <= 1'b0;
      wst(4'h1);
      flame <= 1'b1;
      wst(4'h7);
      chk("flame time", 32'h1, 32'((n >= 315) && (n <= 325)));
      chk("fault", {24'h0, FLT_FLAME}, {24'h0, d[15:8]});
      flame <= 1'b0;
      lok <= 1'b0;
      rmt <= 1'b1;
      wst(4'h0);
      rmt <= 1'b0;
      wst(4'h7);
      chk("init time", 32'h1, 32'((n >= 315) && (n <= 325)));
      chk("fault", {24'h0, FLT_INIT}, {24'h0, d[15:8]});
      lok <= 1'b1;
      btn <= 1'b1;
      wst(4'h0);
      btn <= 1'b0;
      cok <= 1'b0;
      wst(4'h7);
      chk("fault", {24'h0, FLT_CARD}, {24'h0, d[15:8]});
      cok <= 1'b1;
      btn <= 1'b1;
      wst(4'h0);
      btn <= 1'b0;
      wst(4'h1);
      $display("test hold done");
   endtask : t_hold

   task automatic t_card();
      card <= 1'b0;
      wst(4'h7);
      ld(6'h01);
      card <= 1'b1;
      rmt <= 1'b1;
      wst(4'h0);
      rmt <= 1'b0;
      card <= 1'b0;
      wst(4'h7);
      card <= 1'b1;
      btn <= 1'b1;
      wst(4'h0);
      btn <= 1'b0;
      wst(4'h1);
      dem <= 1'b1;
      wst(4'h2);
      flt <= 1'b1;
      wst(4'h7);
      ld(6'h01);
      $display("test card done");
   endtask : t_card

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_setting();
      t_cycle();
      t_trip();
      t_hold();
      t_card();
      wrap_up();
   end

   // The whole run needs a few thousand cycles; this margin is far beyond it.
   initial begin
      repeat (60000) @(posedge clk_i);
      n_mismatch++;
      wrap_up();
   end
endmodule : tb
`default_nettype wire
